// ### common/stwp_pkg.sv
package stwp_pkg;
    // register offsets (printed offsets not all multiples of four: index, byte = 4*index)
    localparam int unsigned TIMER_COUNT_IDX        = 32'h0000_0001;
    localparam int unsigned INTERRUPT_CONTROL_IDX  = 32'h0000_000B;
    localparam int unsigned TIMER_CONFIG_IDX       = 32'h0000_0081;
    localparam int unsigned PORT_A_DIRECTION_IDX   = 32'h0000_0085;
    localparam int unsigned WDT_CONTROL_IDX        = 32'h0000_00C0;
    localparam logic [11:0] TIMER_COUNT_ADDR       = 12'h004;
    localparam logic [11:0] INTERRUPT_CONTROL_ADDR = 12'h02C;
    localparam logic [11:0] TIMER_CONFIG_ADDR      = 12'h204;
    localparam logic [11:0] PORT_A_DIRECTION_ADDR  = 12'h214;
    localparam logic [11:0] WDT_CONTROL_ADDR       = 12'h300;
    // reset values
    localparam logic [7:0]  TIMER_CONFIG_RST       = 8'hFF;
    localparam logic [7:0]  PORT_A_DIRECTION_RST   = 8'h1F;
    localparam logic [7:0]  PORT_A_DIRECTION_MASK  = 8'h1F;
    localparam logic [7:0]  TIMER_COUNT_RST        = 8'h00;
    localparam logic [7:0]  INTERRUPT_CONTROL_RST  = 8'h00;
    // configuration fields
    localparam int unsigned ASSIGN_SELECT_BIT      = 3;
    localparam int unsigned RATIO_LSB              = 0;
    localparam int unsigned RATIO_WIDTH            = 3;
    localparam int unsigned TIMER_OVF_FLAG_BIT     = 2;
    // watchdog control register fields
    localparam int unsigned WDT_CLEAR_BIT          = 0;
    localparam int unsigned WDT_ENABLE_BIT         = 1;
    localparam int unsigned WDT_TIMEOUT_BIT        = 8;
endpackage

// ### rtl/stwp_shared_prescaler.sv
`timescale 1ns/1ps
// Notes on behaviour
// - one 8-bit divider, timer or watchdog
// - assign bit and ratio in config 3:0
// - timer count write clears divider when assigned to timer
// - watchdog clear clears watchdog, and divider when assigned to watchdog
// - divider count invisible to software
// - assignment may change any time
module stwp_shared_prescaler #(
    parameter int unsigned DIV_WIDTH = 8,
    parameter int unsigned WDT_WIDTH = 8
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timerTick,
    input  wire logic        wdtTick,
    output logic             timerIncrement,
    output logic             wdtTimeout,
    output logic       [7:0] portADirection
);
    // refuse widths that the divider and the read word cannot serve
    if (DIV_WIDTH != 8) begin : g_badDivWidth
        $error("divider width must be 8");
    end
    if (WDT_WIDTH < 1 || WDT_WIDTH > 23) begin : g_badWdtWidth
        $error("watchdog width out of range");
    end

    // software visible registers
    logic [7:0]           timerCount_reg;
    logic [7:0]           intControl_reg;
    logic [7:0]           timerConfig_reg;
    logic [7:0]           portADir_reg;

    // watchdog state
    logic                 wdtEnable_reg;
    logic                 wdtTimeout_reg;
    logic [WDT_WIDTH-1:0] wdtCount_reg;

    // divider state, never reachable from the bus
    logic [DIV_WIDTH-1:0] divCount_reg;
    logic [DIV_WIDTH-1:0] divCount_next;

    // registered increment pulse
    logic                 timerInc_reg;

    // bus decode nets
    logic access;
    logic wr;
    logic hitCount;
    logic hitIntCtl;
    logic hitConfig;
    logic hitPortDir;
    logic hitWdt;
    logic hitAny;
    logic wrCount;
    logic wrIntCtl;
    logic wrConfig;
    logic wrPortDir;
    logic wrWdt;
    logic wdtClear;

    // access phase qualifiers
    assign access = psel & penable;
    assign wr     = access & pwrite;

    // address match per register
    assign hitCount   = (paddr == stwp_pkg::TIMER_COUNT_ADDR);
    assign hitIntCtl  = (paddr == stwp_pkg::INTERRUPT_CONTROL_ADDR);
    assign hitConfig  = (paddr == stwp_pkg::TIMER_CONFIG_ADDR);
    assign hitPortDir = (paddr == stwp_pkg::PORT_A_DIRECTION_ADDR);
    assign hitWdt     = (paddr == stwp_pkg::WDT_CONTROL_ADDR);

    // any mapped register; everything else is refused
    assign hitAny = hitCount | hitIntCtl | hitConfig | hitPortDir | hitWdt;

    // write strobes, each valid only in the access phase
    assign wrCount   = wr & hitCount;
    assign wrIntCtl  = wr & hitIntCtl;
    assign wrConfig  = wr & hitConfig;
    assign wrPortDir = wr & hitPortDir;
    assign wrWdt     = wr & hitWdt;
    // watchdog clear instruction is bit 0 of a watchdog control write
    assign wdtClear  = wrWdt & pwdata[stwp_pkg::WDT_CLEAR_BIT];

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~hitAny;

    // divider control nets
    logic       toWatchdog;
    logic [2:0] ratio;
    logic       divIn;
    logic [3:0] timerShift;
    logic [3:0] wdtShift;
    logic [3:0] shiftSel;
    logic [8:0] divLimit;
    logic       divAtLimit;
    logic       divWrap;
    logic       divOut;

    // divider assignment and ratio from config low bits
    assign toWatchdog = timerConfig_reg[stwp_pkg::ASSIGN_SELECT_BIT];
    assign ratio      = timerConfig_reg[stwp_pkg::RATIO_LSB +: stwp_pkg::RATIO_WIDTH];

    // divider input: timer ticks or watchdog ticks, never both
    assign divIn = toWatchdog ? wdtTick : timerTick;

    // timer divides by 2^(ratio+1); watchdog by 2^ratio
    assign timerShift = 4'(ratio) + 4'h1;
    assign wdtShift   = 4'(ratio);
    assign shiftSel   = toWatchdog ? wdtShift : timerShift;

    // terminal count of the divider for the chosen ratio
    assign divLimit   = 9'(9'h001 << shiftSel) - 9'h001;
    assign divAtLimit = ({1'b0, divCount_reg} == divLimit);
    assign divWrap    = divIn & divAtLimit;

    // watchdog at ratio code 0 passes every tick straight through
    // (divide by one), so its output does not wait for a wrap
    assign divOut = toWatchdog ? ((shiftSel == 4'h0) ? divIn : divWrap) : divWrap;

    // divider clear events, each only for the current owner
    logic divClearTimer;
    logic divClearWdt;
    assign divClearTimer = !toWatchdog && wrCount;
    assign divClearWdt   = toWatchdog && wdtClear;

    // divider next value: clearing events have priority over counting
    always_comb begin
        divCount_next = divCount_reg;
        if (divClearTimer) begin
            divCount_next = '0;
        end else if (divClearWdt) begin
            divCount_next = '0;
        end else if (divWrap) begin
            divCount_next = '0;
        end else if (divIn) begin
            divCount_next = divCount_reg + 1'b1;
        end
    end

    // divider register, only reachable through clear events and ticks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCount_reg <= '0;
        end else begin
            divCount_reg <= divCount_next;
        end
    end

    // timer step and overflow nets
    logic       timerStep;
    logic       wdtStepRaw;
    logic       timerOvf;
    logic [7:0] timerCount_next;

    // timer steps on divider output, lost in a cycle that writes the count
    assign timerStep  = !toWatchdog && divOut && !wrCount;
    // watchdog steps on the divider output or on its own ticks
    assign wdtStepRaw = toWatchdog ? divOut : wdtTick;
    // overflow from all ones back to zero
    assign timerOvf   = timerStep && (timerCount_reg == 8'hFF);

    // next timer count: software write wins over a step
    always_comb begin
        timerCount_next = timerCount_reg;
        if (wrCount) begin
            timerCount_next = pwdata[7:0];
        end else if (timerStep) begin
            timerCount_next = timerCount_reg + 8'h01;
        end
    end

    // timer count register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timerCount_reg <= stwp_pkg::TIMER_COUNT_RST;
        end else begin
            timerCount_reg <= timerCount_next;
        end
    end

    // increment pulse, registered from the step; high in the same cycle the new count shows
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timerInc_reg <= 1'b0;
        end else begin
            timerInc_reg <= timerStep;
        end
    end

    // interrupt control; overflow flag set wins over a software clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            intControl_reg <= stwp_pkg::INTERRUPT_CONTROL_RST;
        end else begin
            if (wrIntCtl) begin
                intControl_reg <= pwdata[7:0];
            end
            if (timerOvf) begin
                intControl_reg[stwp_pkg::TIMER_OVF_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // configuration; rewritten at any time, no halt needed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timerConfig_reg <= stwp_pkg::TIMER_CONFIG_RST;
        end else if (wrConfig) begin
            timerConfig_reg <= pwdata[7:0];
        end
    end

    // port direction; unimplemented upper bits stay zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            portADir_reg <= stwp_pkg::PORT_A_DIRECTION_RST;
        end else if (wrPortDir) begin
            portADir_reg <= pwdata[7:0] & stwp_pkg::PORT_A_DIRECTION_MASK;
        end
    end

    // watchdog step and wrap nets
    logic wdtStep;
    logic wdtWrap;
    assign wdtStep = wdtEnable_reg && wdtStepRaw;
    // wrap while all ones; a clear in the same cycle restarts instead
    assign wdtWrap = wdtStep && !wdtClear && (&wdtCount_reg);

    // watchdog enable, written with every watchdog control write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdtEnable_reg <= 1'b0;
        end else if (wrWdt) begin
            wdtEnable_reg <= pwdata[stwp_pkg::WDT_ENABLE_BIT];
        end
    end

    // watchdog counter; clear resets it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdtCount_reg <= '0;
        end else if (wdtClear) begin
            wdtCount_reg <= '0;
        end else if (wdtStep) begin
            wdtCount_reg <= wdtCount_reg + 1'b1;
        end
    end

    // timeout flag, sticky until the next clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdtTimeout_reg <= 1'b0;
        end else if (wdtWrap) begin
            wdtTimeout_reg <= 1'b1;
        end else if (wdtClear) begin
            wdtTimeout_reg <= 1'b0;
        end
    end

    // outputs straight from flip-flops
    assign timerIncrement = timerInc_reg;
    assign wdtTimeout     = wdtTimeout_reg;
    assign portADirection = portADir_reg;

    // read words of the registers, zero padded to the bus width
    logic [31:0] countRead;
    logic [31:0] intCtlRead;
    logic [31:0] configRead;
    logic [31:0] portDirRead;
    logic [31:0] wdtCtlRead;

    assign countRead   = {24'h000000, timerCount_reg};
    assign intCtlRead  = {24'h000000, intControl_reg};
    assign configRead  = {24'h000000, timerConfig_reg};
    assign portDirRead = {24'h000000, portADir_reg};
    // clear bit always reads zero; timeout in bit 8, enable in bit 1
    assign wdtCtlRead  = {23'h000000, wdtTimeout_reg, 6'h00, wdtEnable_reg, 1'b0};

    // read mux; divider count deliberately absent
    always_comb begin
        prdata = 32'h0000_0000;
        if (hitCount) begin
            prdata = countRead;
        end else if (hitIntCtl) begin
            prdata = intCtlRead;
        end else if (hitConfig) begin
            prdata = configRead;
        end else if (hitPortDir) begin
            prdata = portDirRead;
        end else if (hitWdt) begin
            prdata = wdtCtlRead;
        end
    end
endmodule // stwp_shared_prescaler

// ### tb/stwp_shared_prescaler_properties.sv
`timescale 1ns/1ps
module stwp_checker (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        timerTick,
    input wire logic        timerIncrement,
    input wire logic        wdtTimeout
);
    // access decode and assignment tracking
    logic toWdt_reg;
    wire  acc    = psel && penable;
    wire  wr     = acc && pwrite;
    wire  isCfg  = paddr == stwp_pkg::TIMER_CONFIG_ADDR;
    wire  wrTc   = wr && paddr == stwp_pkg::TIMER_COUNT_ADDR;
    wire  wdClr  = wr && paddr == stwp_pkg::WDT_CONTROL_ADDR && pwdata[0];
    wire  mapped = paddr inside {stwp_pkg::TIMER_COUNT_ADDR, stwp_pkg::INTERRUPT_CONTROL_ADDR,
        stwp_pkg::TIMER_CONFIG_ADDR, stwp_pkg::PORT_A_DIRECTION_ADDR, stwp_pkg::WDT_CONTROL_ADDR};
    // mirror of the assignment bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) toWdt_reg <= 1'b1;
        else if (wr && isCfg) toWdt_reg <= pwdata[3];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence clrThenTick;
        wrTc ##1 timerTick;
    endsequence
    AST_NO_DIV_ACCESS: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    AST_CFG_READ: assert property (acc && !pwrite && isCfg |-> prdata[3] == toWdt_reg)
        else $error("assignment bit read wrong");
    AST_TIMER_EXCL: assert property (toWdt_reg |=> !timerIncrement)
        else $error("timer stepped while divider on watchdog");
    AST_INC_CAUSE: assert property (timerIncrement |-> $past(timerTick) && !$past(toWdt_reg))
        else $error("timer step without tick");
    AST_DIV_CLR: assert property (clrThenTick |=> !timerIncrement)
        else $error("divider not cleared by count write");
    AST_WDT_CLR: assert property (wdClr |=> !wdtTimeout [*8])
        else $error("watchdog clear ineffective");
    AST_TO_STICKY: assert property (wdtTimeout && !wdClr |=> wdtTimeout)
        else $error("timeout dropped without clear");
endmodule // stwp_checker
bind stwp_shared_prescaler stwp_checker u_chk (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .timerTick(timerTick), .timerIncrement(timerIncrement),
    .wdtTimeout(wdtTimeout));

// ### tb/tb_shared_timer_watchdog_prescaler.sv
`timescale 1ns/1ps
module tb_shared_timer_watchdog_prescaler;
    localparam logic [11:0] CFG = stwp_pkg::TIMER_CONFIG_ADDR;
    localparam logic [11:0] TC  = stwp_pkg::TIMER_COUNT_ADDR;
    localparam logic [11:0] WD  = stwp_pkg::WDT_CONTROL_ADDR;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic        timerTick, wdtTick, timerIncrement, wdtTimeout;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [7:0]  portADirection;
    int          n_errors, checks, part;
    stwp_shared_prescaler u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timerTick(timerTick), .wdtTick(wdtTick),
        .timerIncrement(timerIncrement), .wdtTimeout(wdtTimeout), .portADirection(portADirection));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // xorshift step and ticks per timer step
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int span(input int r);
        return 2 << r;
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int n, input logic wd);
        repeat (n) begin
            @(posedge clk);
            timerTick <= !wd;
            wdtTick <= wd;
            @(posedge clk);
            timerTick <= 1'b0;
            wdtTick <= 1'b0;
        end
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, timerTick, wdtTick, resetn} = '0;
        paddr = '0;
        pwdata = '0;
        seed = 32'h23109675;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        apb(0, CFG, 0); chk({err, rd}, 33'hFF);
        apb(0, 12'h0F0, 0); chk({err, rd}, {1'b1, 32'h0});
        apb(1, WD, 32'h1);
        for (int r = 0; r < 8; r++) begin
            seed = xs(seed);
            apb(1, CFG, 32'(r));
            part = int'(seed % 32'(span(r)));
            tick(part, 1'b0);
            apb(1, TC, 0);
            tick(span(r) - 1, 1'b0);
            apb(0, TC, 0); chk({err, rd}, 33'h0);
            tick(1, 1'b0);
            apb(0, TC, 0); chk({err, rd}, 33'h1);
        end
        apb(1, WD, 32'h3); apb(1, TC, 0); apb(1, CFG, 32'h0F);
        apb(1, WD, 32'h3); apb(1, CFG, 32'h09);
        tick(5, 1'b0);
        apb(0, TC, 0); chk({err, rd}, 33'h0);
        tick(101, 1'b1);
        apb(1, WD, 32'h3);
        tick(span(8) - 1, 1'b1);
        chk(wdtTimeout, 0);
        tick(1, 1'b1);
        repeat (2) @(posedge clk);
        chk(wdtTimeout, 1);
        apb(0, WD, 0); chk({err, rd}, 33'h102);
        apb(1, WD, 32'h1); apb(1, CFG, 32'h00);
        apb(1, TC, 32'hFF); tick(2, 1'b0);
        apb(0, TC, 0); chk({err, rd}, 33'h0);
        apb(0, stwp_pkg::INTERRUPT_CONTROL_ADDR, 0); chk({err, rd}, 33'h4);
        apb(1, stwp_pkg::PORT_A_DIRECTION_ADDR, 32'hEA);
        @(posedge clk);
        chk(portADirection, 8'h0A);
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule // tb_shared_timer_watchdog_prescaler
